//--- rtl/flash_ctl_cfg.svh
`ifndef FLASH_CTL_CFG_SVH
`define FLASH_CTL_CFG_SVH
// Contract
// R1: programming only clears bits, erase sets them
// R2: hardware times operations and stalls the core
// R3: write enable routes moves to flash, sticky
// R4: keys 0xa5 then 0xf1 arm one operation
// R5: wrong or misordered key disables until reset
// R6: operation before keys disables until reset
// R7: lock returns after every operation
// R8: supply monitor off makes attempt raise error reset
// R9: erase wipes whole 512-byte page to 0xff
// R10: software byte write sequence is software's job
// R11: software masks interrupts around flash operations
// R12: software erases a byte before rewriting it
// R13: debug port programs flash without keys
// R14: security forbidden targets are refused
// R15: write needs write enable, erase also erase enable
// R16: error reset sets the flash error flag
// R17: with write enable clear moves go to ram
`define KEY_FIRST       8'ha5
`define KEY_SECOND      8'hf1
`define ERASED_BYTE     8'hff
`define ADDR_W          14
`define PAGE_BITS       9
`define RESERVED_BASE   14'h3e00
`define LOCK_PAGE       5'h1e
`define CLK_PERIOD_NS   50
`define WRITE_TIME_NS   40000
`define ERASE_TIME_NS   20000000
`define WRITE_CYCLES    ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES    ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           20
`endif

//--- rtl/flash_ctl_pkg.sv
`include "flash_ctl_cfg.svh"
package flash_ctl_pkg;
	typedef enum logic [3:0] {
		KEY_LOCKED   = 4'h1,
		KEY_HALF     = 4'h2,
		KEY_ARMED    = 4'h4,
		KEY_DISABLED = 4'h8
	} key_state_e;
	typedef enum logic [3:0] {
		OP_IDLE  = 4'h1,
		OP_READ  = 4'h2,
		OP_PROG  = 4'h4,
		OP_ERASE = 4'h8
	} op_state_e;
	typedef struct packed {
		key_state_e           key;
		op_state_e            op;
		logic [`CNT_W-1:0]    cnt;
		logic [`ADDR_W-1:0]   addr;
		logic [7:0]           data;
		logic                 store_write_enable;
		logic                 store_erase_enable;
		logic                 xram_wr;
		logic                 err_rst;
		logic                 err_pending;
		logic                 flash_error_flag;
	} state_s;
endpackage : flash_ctl_pkg

//--- rtl/flash_program_erase_control.sv
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
module flash_program_erase_control #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES,
	parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               sys_rst,
	// program store control
	input  wire logic               program_store_control_wr,
	input  wire logic [1:0]         program_store_control_wdata,
	output logic                    store_write_enable,
	output logic                    store_erase_enable,
	// key register
	input  wire logic               flash_key_register_wr,
	input  wire logic [7:0]         flash_key_register_wdata,
	output logic                    key_armed,
	output logic                    key_disabled,
	// cpu moves
	input  wire logic               external_move_write,
	input  wire logic [`ADDR_W-1:0] move_addr,
	input  wire logic [7:0]         move_wdata,
	output logic                    cpu_stall,
	output logic                    xram_wr,
	output logic [`ADDR_W-1:0]      xram_addr,
	output logic [7:0]              xram_wdata,
	// supply monitor and security
	input  wire logic               vmon_enable,
	input  wire logic               vmon_reset_enable,
	input  wire logic               any_page_locked,
	input  wire logic               exec_from_locked,
	// debug port
	input  wire logic               dbg_write,
	input  wire logic               dbg_erase,
	input  wire logic [`ADDR_W-1:0] dbg_addr,
	input  wire logic [7:0]         dbg_wdata,
	output logic                    dbg_busy,
	// reset source
	output logic                    flash_error_device_reset,
	output logic                    flash_error_flag,
	// flash array
	input  wire logic [7:0]         flash_rdata,
	output logic [`ADDR_W-1:0]      flash_addr,
	output logic [7:0]              flash_wdata,
	output logic                    flash_prog,
	output logic                    flash_erase
);
	flash_ctl_pkg::state_s st;
	flash_ctl_pkg::state_s next_st;

	logic sw_erase;
	logic sw_forbidden;
	logic dbg_forbidden;
	logic dbg_req;

	assign sw_erase = st.store_erase_enable;
	assign dbg_req  = dbg_write | dbg_erase;

	// security checks on the addressed page
	always_comb
	begin
		sw_forbidden = (move_addr >= `RESERVED_BASE)
			| (sw_erase & (move_addr[`ADDR_W-1:`PAGE_BITS] == `LOCK_PAGE))
			| (any_page_locked & ~exec_from_locked); // R14
		dbg_forbidden = (dbg_addr >= `RESERVED_BASE) | any_page_locked; // R14
	end

	always_comb
	begin
		next_st = st;
		next_st.xram_wr = 1'b0;
		next_st.err_rst = 1'b0;
		if (program_store_control_wr)
		begin
			next_st.store_write_enable = program_store_control_wdata[0]; // R3
			next_st.store_erase_enable = program_store_control_wdata[1];
		end
		if (flash_key_register_wr)
		begin
			case (st.key)
				flash_ctl_pkg::KEY_LOCKED:
					next_st.key = (flash_key_register_wdata == `KEY_FIRST) ? flash_ctl_pkg::KEY_HALF
						: flash_ctl_pkg::KEY_DISABLED; // R4 R5
				flash_ctl_pkg::KEY_HALF:
					next_st.key = (flash_key_register_wdata == `KEY_SECOND) ? flash_ctl_pkg::KEY_ARMED
						: flash_ctl_pkg::KEY_DISABLED; // R4 R5
				default:
					next_st.key = flash_ctl_pkg::KEY_DISABLED; // R5
			endcase
		end
		case (st.op)
			flash_ctl_pkg::OP_IDLE:
			begin
				if (external_move_write)
				begin
					next_st.addr = move_addr;
					next_st.data = move_wdata;
					if (!st.store_write_enable)
						next_st.xram_wr = 1'b1; // R17
					else if (!(vmon_enable & vmon_reset_enable))
					begin
						next_st.err_rst = 1'b1; // R8
						next_st.err_pending = 1'b1;
					end
					else if (st.key != flash_ctl_pkg::KEY_ARMED)
						next_st.key = flash_ctl_pkg::KEY_DISABLED; // R6
					else if (sw_forbidden)
					begin
						next_st.err_rst = 1'b1; // R14
						next_st.err_pending = 1'b1;
					end
					else
					begin
						next_st.key = flash_ctl_pkg::KEY_LOCKED; // R7
						next_st.cnt = '0;
						next_st.op = sw_erase ? flash_ctl_pkg::OP_ERASE : flash_ctl_pkg::OP_READ; // R15 R9
						if (sw_erase)
							next_st.addr = {move_addr[`ADDR_W-1:`PAGE_BITS], {`PAGE_BITS{1'b0}}}; // R9
					end
				end
				else if (dbg_req && !dbg_forbidden)
				begin
					next_st.cnt = '0; // R13
					next_st.data = dbg_wdata;
					next_st.addr = dbg_erase ? {dbg_addr[`ADDR_W-1:`PAGE_BITS], {`PAGE_BITS{1'b0}}} : dbg_addr;
					next_st.op = dbg_erase ? flash_ctl_pkg::OP_ERASE : flash_ctl_pkg::OP_READ;
				end
			end
			flash_ctl_pkg::OP_READ:
			begin
				next_st.data = st.data & flash_rdata; // R1
				next_st.op = flash_ctl_pkg::OP_PROG;
			end
			flash_ctl_pkg::OP_PROG:
			begin
				next_st.cnt = st.cnt + 1'b1; // R2
				if (st.cnt == `CNT_W'(WRITE_CYCLES - 1))
					next_st.op = flash_ctl_pkg::OP_IDLE;
			end
			flash_ctl_pkg::OP_ERASE:
			begin
				next_st.cnt = st.cnt + 1'b1; // R2
				if (st.cnt == `CNT_W'(ERASE_CYCLES - 1))
					next_st.op = flash_ctl_pkg::OP_IDLE;
			end
			default:
				next_st.op = flash_ctl_pkg::OP_IDLE;
		endcase
		if (sys_rst)
		begin
			next_st.key = flash_ctl_pkg::KEY_LOCKED; // R5
			next_st.op = flash_ctl_pkg::OP_IDLE;
			next_st.store_write_enable = 1'b0;
			next_st.store_erase_enable = 1'b0;
			next_st.xram_wr = 1'b0;
			next_st.err_rst = 1'b0;
			next_st.flash_error_flag = st.err_pending; // R16
			next_st.err_pending = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			st.key <= flash_ctl_pkg::KEY_LOCKED;
			st.op <= flash_ctl_pkg::OP_IDLE;
		end
		else
			st <= next_st;
	end

	assign store_write_enable = st.store_write_enable;
	assign store_erase_enable = st.store_erase_enable;
	assign key_armed = st.key == flash_ctl_pkg::KEY_ARMED;
	assign key_disabled = st.key == flash_ctl_pkg::KEY_DISABLED;
	assign cpu_stall = st.op != flash_ctl_pkg::OP_IDLE; // R2
	assign dbg_busy = cpu_stall;
	assign xram_wr = st.xram_wr;
	assign xram_addr = st.addr;
	assign xram_wdata = st.data;
	assign flash_error_device_reset = st.err_rst;
	assign flash_error_flag = st.flash_error_flag;
	assign flash_addr = st.addr;
	assign flash_wdata = st.data;
	assign flash_prog = st.op == flash_ctl_pkg::OP_PROG;
	assign flash_erase = st.op == flash_ctl_pkg::OP_ERASE;

	logic key_state_is_locked;
	assign key_state_is_locked = st.key == flash_ctl_pkg::KEY_LOCKED && !sys_rst;

	sequence s_first_key;
		flash_key_register_wr && flash_key_register_wdata == `KEY_FIRST && key_state_is_locked;
	endsequence
	sequence s_second_key;
		flash_key_register_wr && flash_key_register_wdata == `KEY_SECOND && !sys_rst;
	endsequence

	a_key_order: assert property (@(posedge clk) disable iff (!arst_n) // R4
		s_first_key ##1 (!flash_key_register_wr && !sys_rst && !cpu_stall && !external_move_write)[*1]
			##1 s_second_key |=> key_armed)
		else $error("keys in order did not arm");
	a_disable_sticky: assert property (@(posedge clk) disable iff (!arst_n) // R5
		key_disabled && !sys_rst |=> key_disabled)
		else $error("disabled key state left without reset");
	a_early_move: assert property (@(posedge clk) disable iff (!arst_n) // R6
		external_move_write && !cpu_stall && store_write_enable && vmon_enable && vmon_reset_enable
			&& !key_armed && !sys_rst |=> key_disabled && !cpu_stall)
		else $error("move before keys did not disable");
	a_relock: assert property (@(posedge clk) disable iff (!arst_n) // R7
		$rose(cpu_stall) && $past(external_move_write) |-> !key_armed)
		else $error("key stayed armed after starting operation");
	a_vmon_error: assert property (@(posedge clk) disable iff (!arst_n) // R8
		external_move_write && !cpu_stall && store_write_enable && !(vmon_enable && vmon_reset_enable)
			&& !sys_rst |=> flash_error_device_reset && !cpu_stall)
		else $error("supply monitor off without error reset");
	a_prog_clears: assert property (@(posedge clk) disable iff (!arst_n) // R1
		$rose(flash_prog) |-> (flash_wdata & ~$past(flash_rdata)) == 8'h00)
		else $error("program data sets a bit");
	a_erase_page: assert property (@(posedge clk) disable iff (!arst_n) // R9
		flash_erase |-> flash_addr[`PAGE_BITS-1:0] == '0)
		else $error("erase address not page aligned");
	a_write_time: assert property (@(posedge clk) disable iff (!arst_n) // R2
		$fell(flash_prog) && !$past(sys_rst) |-> !cpu_stall && $past(st.cnt) == `CNT_W'(WRITE_CYCLES - 1))
		else $error("program did not end after its timed count");
	a_ram_route: assert property (@(posedge clk) disable iff (!arst_n) // R17
		external_move_write && !cpu_stall && !store_write_enable && !sys_rst
			|=> xram_wr && !cpu_stall && !flash_prog)
		else $error("move with write enable clear not sent to ram");
	a_error_flag: assert property (@(posedge clk) disable iff (!arst_n) // R16
		flash_error_device_reset ##1 (sys_rst && !flash_error_device_reset) |=> flash_error_flag)
		else $error("error flag not set after error reset");
endmodule : flash_program_erase_control

//--- dv/flash_array_model.sv
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
module flash_array_model (
	// clock
	input  wire logic               clk,
	// array port
	input  wire logic [`ADDR_W-1:0] flash_addr,
	input  wire logic [7:0]         flash_wdata,
	input  wire logic               flash_prog,
	input  wire logic               flash_erase,
	output logic [7:0]              flash_rdata
);
	logic [7:0] mem [0:(1<<`ADDR_W)-1];
	initial
	begin
		foreach (mem[i])
			mem[i] = `ERASED_BYTE;
	end
	// read byte stands in the same cycle as its address
	assign flash_rdata = mem[flash_addr];
	always @(posedge clk)
	begin
		// stores the byte as driven, so a missing merge in the controller shows up
		if (flash_prog)
			mem[flash_addr] <= flash_wdata;
		if (flash_erase)
			for (int i = 0; i < (1 << `PAGE_BITS); i++)
				mem[{flash_addr[`ADDR_W-1:`PAGE_BITS], i[`PAGE_BITS-1:0]}] <= `ERASED_BYTE;
	end
endmodule : flash_array_model

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
	logic clk, arst_n, sys_rst, program_store_control_wr, flash_key_register_wr, external_move_write;
	logic vmon_enable, vmon_reset_enable, any_page_locked, exec_from_locked, dbg_write, dbg_erase;
	logic store_write_enable, store_erase_enable, key_armed, key_disabled, cpu_stall, xram_wr, dbg_busy;
	logic flash_error_device_reset, flash_error_flag, flash_prog, flash_erase, xw, er, st;
	logic [1:0]         program_store_control_wdata;
	logic [7:0]         flash_key_register_wdata, move_wdata, xram_wdata, dbg_wdata, flash_rdata, flash_wdata;
	logic [`ADDR_W-1:0] move_addr, xram_addr, dbg_addr, flash_addr;
	int                 error_cnt, num_checks, cyc;
	flash_program_erase_control #(.WRITE_CYCLES(4), .ERASE_CYCLES(8)) DUT (.clk, .arst_n, .sys_rst,
		.program_store_control_wr, .program_store_control_wdata, .store_write_enable, .store_erase_enable,
		.flash_key_register_wr, .flash_key_register_wdata, .key_armed, .key_disabled, .external_move_write,
		.move_addr, .move_wdata, .cpu_stall, .xram_wr, .xram_addr, .xram_wdata, .vmon_enable, .vmon_reset_enable,
		.any_page_locked, .exec_from_locked, .dbg_write, .dbg_erase, .dbg_addr, .dbg_wdata, .dbg_busy,
		.flash_error_device_reset, .flash_error_flag, .flash_rdata, .flash_addr, .flash_wdata, .flash_prog,
		.flash_erase);
	flash_array_model u_flash (.clk, .flash_addr, .flash_wdata, .flash_prog, .flash_erase, .flash_rdata);
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task close_out();
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task rst();
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
	endtask : rst
	task ctl(input logic [1:0] v);
		@(posedge clk);
		program_store_control_wdata <= v;
		program_store_control_wr <= 1'b1;
		@(posedge clk);
		program_store_control_wr <= 1'b0;
	endtask : ctl
	task key(input logic [7:0] v);
		@(posedge clk);
		flash_key_register_wdata <= v;
		flash_key_register_wr <= 1'b1;
		@(posedge clk);
		flash_key_register_wr <= 1'b0;
	endtask : key
	task arm();
		key(`KEY_FIRST);
		key(`KEY_SECOND);
		@(posedge clk);
		#1;
	endtask : arm
	task wt();
		st = 0;
		repeat (3)
		begin
			if (cpu_stall === 1'b1)
				st = 1;
			@(posedge clk);
			#1;
		end
		for (int i = 0; i < 20 && cpu_stall !== 1'b0; i++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK("stall_end", 1'b0, cpu_stall)
	endtask : wt
	task mv(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		move_addr <= a;
		move_wdata <= d;
		external_move_write <= 1'b1;
		@(posedge clk);
		external_move_write <= 1'b0;
		#1;
		xw = xram_wr;
		er = flash_error_device_reset;
		wt();
	endtask : mv
	task t_prog();
		rst();
		ctl(2'b01);
		arm();
		`CHK("armed", 1'b1, key_armed)
		mv(14'h0010, 8'h5a);
		`CHK("stall", 1'b1, st)
		`CHK("byte", 8'h5a, u_flash.mem[14'h0010])
		`CHK("relock", 1'b0, key_armed)
		`CHK("wen", 1'b1, store_write_enable)
		arm();
		mv(14'h0010, 8'h0f);
		`CHK("and", 8'h0a, u_flash.mem[14'h0010])
		ctl(2'b11);
		arm();
		mv(14'h01f3, 8'h00);
		`CHK("erase", `ERASED_BYTE, u_flash.mem[14'h0010])
		`CHK("een", 1'b1, store_erase_enable)
		ctl(2'b01);
		arm();
		mv(14'h0010, 8'h3c);
		`CHK("rewrite", 8'h3c, u_flash.mem[14'h0010])
		ctl(2'b00);
		#1;
		`CHK("wen_off", 1'b0, store_write_enable)
	endtask : t_prog
	task t_ram();
		ctl(2'b00);
		mv(14'h0020, 8'h33);
		`CHK("xram_wr", 1'b1, xw)
		`CHK("xram_addr", 14'h0020, xram_addr)
		`CHK("xram_wdata", 8'h33, xram_wdata)
		ctl(2'b10);
		arm();
		mv(14'h0022, 8'h00);
		`CHK("ee_only", 1'b1, xw)
		`CHK("ee_keep", `ERASED_BYTE, u_flash.mem[14'h0022])
	endtask : t_ram
	task t_err();
		rst();
		vmon_reset_enable <= 1'b0;
		ctl(2'b01);
		arm();
		@(posedge clk);
		move_addr <= 14'h0030;
		move_wdata <= 8'h00;
		external_move_write <= 1'b1;
		@(posedge clk);
		external_move_write <= 1'b0;
		#1;
		`CHK("vmon_err", 1'b1, flash_error_device_reset)
		@(posedge clk);
		vmon_reset_enable <= 1'b1;
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("vmon_keep", `ERASED_BYTE, u_flash.mem[14'h0030])
		`CHK("err_flag", 1'b1, flash_error_flag)
		ctl(2'b01);
		arm();
		mv(`RESERVED_BASE, 8'h00);
		`CHK("rsv_err", 1'b1, er)
		rst();
		ctl(2'b11);
		arm();
		mv(14'h3c00, 8'h00);
		`CHK("lock_page_err", 1'b1, er)
		`CHK("lock_page_keep", `ERASED_BYTE, u_flash.mem[14'h3c00])
		rst();
		any_page_locked <= 1'b1;
		ctl(2'b01);
		arm();
		mv(14'h0080, 8'h77);
		`CHK("locked_err", 1'b1, er)
		rst();
		exec_from_locked <= 1'b1;
		ctl(2'b01);
		arm();
		mv(14'h0080, 8'h77);
		`CHK("locked_exec_ok", 1'b0, er)
		`CHK("locked_exec_byte", 8'h77, u_flash.mem[14'h0080])
		{any_page_locked, exec_from_locked} <= 2'b00;
	endtask : t_err
	task t_key();
		rst();
		ctl(2'b01);
		key(`KEY_FIRST);
		key(8'h00);
		@(posedge clk);
		#1;
		`CHK("bad_key", 1'b1, key_disabled)
		arm();
		`CHK("stay_off", 1'b0, key_armed)
		mv(14'h0040, 8'h00);
		`CHK("off_keep", `ERASED_BYTE, u_flash.mem[14'h0040])
		rst();
		ctl(2'b01);
		mv(14'h0050, 8'h00);
		`CHK("early", 1'b1, key_disabled)
	endtask : t_key
	task t_dbg();
		rst();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			any_page_locked <= (k == 3);
			dbg_addr <= (k == 1) ? `RESERVED_BASE : ((k == 3) ? 14'h0070 : 14'h0060);
			dbg_wdata <= 8'h12;
			dbg_write <= (k != 2);
			dbg_erase <= (k == 2);
			@(posedge clk);
			dbg_write <= 1'b0;
			dbg_erase <= 1'b0;
			#1;
			`CHK("dbg_busy", (k == 0 || k == 2), dbg_busy)
			wt();
			if (k == 0)
				`CHK("dbg_wr", 8'h12, u_flash.mem[14'h0060])
			else if (k == 2)
				`CHK("dbg_erase", `ERASED_BYTE, u_flash.mem[14'h0060])
			else
				`CHK("dbg_refuse", `ERASED_BYTE, u_flash.mem[dbg_addr])
		end
		any_page_locked <= 1'b0;
	endtask : t_dbg
	initial
	begin
		{clk, sys_rst, program_store_control_wr, flash_key_register_wr, external_move_write} = '0;
		{any_page_locked, exec_from_locked, dbg_write, dbg_erase} = '0;
		{vmon_enable, vmon_reset_enable} = 2'b11;
		{program_store_control_wdata, flash_key_register_wdata, move_wdata, dbg_wdata} = '0;
		{move_addr, dbg_addr} = '0;
		arst_n = 1'b0;
		t_prog();
		t_ram();
		t_err();
		t_key();
		t_dbg();
		close_out();
	end
endmodule : testbench
